// ==== design/pwm_timer.sv ====
// The register addresses and the plain strobed port were left to the implementer.
module pwm_timer (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [pwm_timer_pkg::AW-1:0] addr_i,
   input wire logic [pwm_timer_pkg::CW-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [pwm_timer_pkg::CW-1:0] rdata_o,
   output logic [pwm_timer_pkg::NCH-1:0] chan_pin_a_o,
   output logic [pwm_timer_pkg::NCH-1:0] chan_pin_a_oe_n_o,
   output logic ch3_pin_b_o,
   output logic ch3_pin_b_oe_n_o,
   output logic ch4_pin_b_o,
   output logic ch4_pin_b_oe_n_o,
   output logic ch4_aux_pin_a_o,
   output logic ch4_aux_pin_b_o
);
   import pwm_timer_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [CW-1:0] cnt_q [NCH];
   logic [CW-1:0] gra_q [NCH];
   logic [CW-1:0] grb_q [NCH];
   logic [CTRL_W-1:0] ctrl_q [NCH];
   logic [STAT_W-1:0] stat_q [NCH];
   logic [NCH-1:0] str_q;
   logic [NCH-1:0] wave_q;
   logic [NCH-1:0] pin_a_q;
   logic [NCH-1:0] pin_a_oe_n_q;
   logic [NCH-1:0] base_run;
   logic [NCH-1:0] run;
   logic [NCH-1:0] ma;
   logic [NCH-1:0] mb;
   logic [NCH-1:0] clr;
   logic [NCH-1:0] sync_bit;
   logic [NCH-1:0] sync_src;
   logic [2:0] pair_p_q;
   logic [2:0] pair_s_q;
   logic [2:0] sec;
   logic [2:0] presc_q;
   logic [CW-1:0] rdata_q;
   logic dir_q;
   logic dir_d;
   logic pin3b_q;
   logic pin4b_q;
   logic aux_a_q;
   logic aux_b_q;
   logic pinb_oe_n_q;
   mode_t mode_q;

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   wire [2:0] acc_ch = addr_i[CH_SEL_LSB +: 3];
   wire [2:0] acc_reg = addr_i[REG_SEL_LSB +: 3];
   wire acc_ok = addr_i[1:0] == 2'h0;
   wire acc_in_ch = acc_ok & (acc_ch < 3'(NCH));
   wire wr_start = wr_i & (addr_i == ADDR_START);
   wire wr_mode = wr_i & (addr_i == ADDR_MODE);
   // a counter write to any synchronised channel presets all of them
   wire wsync_hit = acc_in_ch & sync_bit[acc_ch];
   wire is_rsync = mode_q == MODE_RSYNC;
   wire is_compl = mode_q == MODE_COMPL;
   wire is_comb = is_rsync | is_compl;
   wire [1:0] mode_code = is_rsync ? MODE_CODE_RSYNC : (is_compl ? MODE_CODE_COMPL : MODE_CODE_NORMAL);
   wire [1:0] wmode = wdata_i[1:0];
   // an unlisted mode code falls back to normal operation
   wire mode_t mode_d = (wmode == MODE_CODE_RSYNC) ? MODE_RSYNC :
                        (wmode == MODE_CODE_COMPL) ? MODE_COMPL : MODE_NORMAL;

   // ----------------------------------------------------------------
   // up/down direction shared by channels 3 and 4
   // ----------------------------------------------------------------
   // the counters turn on the limit value itself with no overshoot cycle, so a
   // transition point equal to the limit toggles once per cycle: keep it below
   always_comb begin
      dir_d = dir_q;
      if (!is_compl) begin
         dir_d = 1'b0;
      end else if (base_run[3] && !dir_q && cnt_q[3] == gra_q[3]) begin
         dir_d = 1'b1;
      end else if (base_run[3] && dir_q && cnt_q[4] == CNT_RST) begin
         dir_d = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // channels
   // ----------------------------------------------------------------
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      wire [1:0] cks = ctrl_q[i][CTRL_CKS_LSB +: 2];
      wire [2:0] pmask = (cks == CKS_DIV8) ? PRESC_M8 : (cks == CKS_DIV4) ? PRESC_M4 :
                         (cks == CKS_DIV2) ? PRESC_M2 : PRESC_M1;
      wire tick = (presc_q & pmask) == pmask;
      wire pwm_en = ctrl_q[i][CTRL_PWM_BIT];
      wire clr_t cclr = clr_t'(ctrl_q[i][CTRL_CCLR_LSB +: 2]);
      wire own = ((i == 3) || (i == 4)) && is_comb;
      wire lock = (i == 4) && is_compl;
      wire detach = (i == 4) && is_comb;
      wire rs3 = (i == 3) && is_rsync;
      wire down = ((i == 3) || (i == 4)) && is_compl && dir_d;
      wire sel = acc_in_ch & (acc_ch == 3'(i));
      wire wr_gra = wr_i & sel & (acc_reg == REG_GRA);
      wire wr_grb = wr_i & sel & (acc_reg == REG_GRB);
      wire wr_ctrl = wr_i & sel & (acc_reg == REG_CTRL);
      wire load = wr_i & (acc_reg == REG_CNT) & (sel | (sync_bit[i] & wsync_hit));
      wire [STAT_W-1:0] sclr = (wr_i & sel & (acc_reg == REG_STAT)) ? wdata_i[STAT_W-1:0] : STAT_RST;
      wire sync_clr = sync_bit[i] & (cclr == CLR_SYNC) & (|sync_src) & ~own;
      logic [CW-1:0] cnt_d;
      logic [STAT_W-1:0] sset;
      logic wave_d;

      assign base_run[i] = str_q[i] & tick;
      // in complementary mode both counters step on channel 3 timing
      assign run[i] = lock ? base_run[3] : base_run[i];
      // channel 4 registers feed the pairs, not its own counter
      assign ma[i] = run[i] & (cnt_q[i] == gra_q[i]) & ~detach;
      assign mb[i] = run[i] & (cnt_q[i] == grb_q[i]) & ~detach;
      assign clr[i] = rs3 ? ma[i] : (~own & (((cclr == CLR_GRA) & ma[i]) | ((cclr == CLR_GRB) & mb[i])));
      assign sync_bit[i] = ctrl_q[i][CTRL_SYNC_BIT];
      assign sync_src[i] = sync_bit[i] & clr[i];

      always_comb begin
         cnt_d = cnt_q[i];
         if (load) begin
            cnt_d = wdata_i;
         end else if (clr[i] | sync_clr) begin
            cnt_d = CNT_RST;
         end else if (run[i]) begin
            cnt_d = down ? cnt_q[i] - CW'(1) : cnt_q[i] + CW'(1);
         end
      end

      always_comb begin
         sset = STAT_RST;
         sset[STAT_MFA_BIT] = ma[i] & ~((i == 3) && is_compl && dir_q);
         sset[STAT_MFB_BIT] = mb[i];
         if ((i == 3) && is_compl) begin
            sset[STAT_OVF_BIT] = 1'b0;
         end else if (lock) begin
            sset[STAT_OVF_BIT] = run[i] & dir_q & (cnt_q[i] == CNT_RST);
         end else begin
            sset[STAT_OVF_BIT] = run[i] & ~load & ~clr[i] & ~sync_clr & (cnt_q[i] == CNT_MAX);
         end
      end

      always_comb begin
         wave_d = wave_q[i];
         if (ma[i] && mb[i]) begin
            wave_d = wave_q[i];
         end else if (ma[i]) begin
            wave_d = 1'b1;
         end else if (mb[i]) begin
            wave_d = 1'b0;
         end
      end

      // a compare value beyond the period never matches, so the level
      // set by the other register holds: 0% or 100% duty
      wire pair_pin = (i == 3) ? pair_p_q[0] : pair_p_q[1];
      wire pin_d = own ? pair_pin : (pwm_en & wave_q[i]);

      always_ff @(posedge clk_i) begin
         if (!resetn_i) begin
            cnt_q[i] <= CNT_RST;
         end else begin
            cnt_q[i] <= cnt_d;
         end
      end

      always_ff @(posedge clk_i) begin
         if (!resetn_i) begin
            gra_q[i] <= GR_RST;
            grb_q[i] <= GR_RST;
         end else begin
            if (wr_gra) begin
               gra_q[i] <= wdata_i;
            end
            if (wr_grb) begin
               grb_q[i] <= wdata_i;
            end
         end
      end

      always_ff @(posedge clk_i) begin
         if (!resetn_i) begin
            ctrl_q[i] <= CTRL_RST;
         end else if (wr_ctrl) begin
            ctrl_q[i] <= wdata_i[CTRL_W-1:0];
         end
      end

      // a new event wins over a clear in the same cycle
      always_ff @(posedge clk_i) begin
         if (!resetn_i) begin
            stat_q[i] <= STAT_RST;
         end else begin
            stat_q[i] <= (stat_q[i] & ~sclr) | sset;
         end
      end

      always_ff @(posedge clk_i) begin
         if (!resetn_i) begin
            wave_q[i] <= 1'b0;
         end else begin
            wave_q[i] <= wave_d;
         end
      end

      always_ff @(posedge clk_i) begin
         if (!resetn_i) begin
            pin_a_q[i] <= 1'b0;
            pin_a_oe_n_q[i] <= 1'b1;
         end else begin
            pin_a_q[i] <= pin_d;
            pin_a_oe_n_q[i] <= ~(own | pwm_en);
         end
      end
   end

   // ----------------------------------------------------------------
   // combined-mode output pairs
   // ----------------------------------------------------------------
   for (genvar k = 0; k < 3; k++) begin : g_pair
      wire [CW-1:0] preg = (k == 0) ? grb_q[3] : ((k == 1) ? gra_q[4] : grb_q[4]);
      wire m3 = base_run[3] & (cnt_q[3] == preg);
      wire m4 = base_run[3] & (cnt_q[4] == preg);
      logic p_d;
      logic s_d;

      always_comb begin
         p_d = 1'b1;
         s_d = 1'b0;
         if (is_rsync) begin
            p_d = pair_p_q[k] ^ (m3 ^ clr[3]);
         end else if (is_compl) begin
            // the leading counter drops the primary before the lagging
            // one raises the secondary, and the reverse on the way down
            p_d = pair_p_q[k] ^ m3;
            s_d = pair_s_q[k] ^ m4;
         end
      end

      assign sec[k] = is_rsync ? ~pair_p_q[k] : (is_compl & pair_s_q[k]);

      always_ff @(posedge clk_i) begin
         if (!resetn_i) begin
            pair_p_q[k] <= 1'b1;
         end else begin
            pair_p_q[k] <= p_d;
         end
      end

      always_ff @(posedge clk_i) begin
         if (!resetn_i) begin
            pair_s_q[k] <= 1'b0;
         end else begin
            pair_s_q[k] <= s_d;
         end
      end
   end

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   // unmapped and misaligned addresses read as zero; the bus never waits
   wire [CW-1:0] ctrl_rd = {{(CW-CTRL_W){1'b0}}, ctrl_q[acc_ch]};
   wire [CW-1:0] stat_rd = {{(CW-STAT_W){1'b0}}, stat_q[acc_ch]};
   wire [CW-1:0] str_rd = {{(CW-NCH){1'b0}}, str_q};
   wire [CW-1:0] mode_rd = {{(CW-MODE_DIR_BIT-1){1'b0}}, dir_q, mode_code};
   wire [CW-1:0] ch_rd = (acc_reg == REG_CTRL) ? ctrl_rd :
                         (acc_reg == REG_CNT) ? cnt_q[acc_ch] :
                         (acc_reg == REG_GRA) ? gra_q[acc_ch] :
                         (acc_reg == REG_GRB) ? grb_q[acc_ch] :
                         (acc_reg == REG_STAT) ? stat_rd : '0;
   wire [CW-1:0] rd_val = acc_in_ch ? ch_rd :
                          (addr_i == ADDR_START) ? str_rd :
                          (addr_i == ADDR_MODE) ? mode_rd : '0;

   // ----------------------------------------------------------------
   // global registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         str_q <= STR_RST;
      end else if (wr_start) begin
         str_q <= wdata_i[NCH-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         mode_q <= MODE_NORMAL;
      end else if (wr_mode) begin
         mode_q <= mode_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         dir_q <= 1'b0;
      end else begin
         dir_q <= dir_d;
      end
   end

   // the prescaler runs free, so a divided clock starts at any phase
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         presc_q <= PRESC_RST;
      end else begin
         presc_q <= presc_q + 3'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rd_i ? rd_val : '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         pin3b_q <= 1'b0;
         pin4b_q <= 1'b0;
         aux_a_q <= 1'b0;
         aux_b_q <= 1'b0;
         pinb_oe_n_q <= 1'b1;
      end else begin
         pin3b_q <= sec[0];
         pin4b_q <= is_comb & pair_p_q[2];
         aux_a_q <= sec[1];
         aux_b_q <= sec[2];
         pinb_oe_n_q <= ~is_comb;
      end
   end

   assign rdata_o = rdata_q;
   assign chan_pin_a_o = pin_a_q;
   assign chan_pin_a_oe_n_o = pin_a_oe_n_q;
   assign ch3_pin_b_o = pin3b_q;
   assign ch3_pin_b_oe_n_o = pinb_oe_n_q;
   assign ch4_pin_b_o = pin4b_q;
   assign ch4_pin_b_oe_n_o = pinb_oe_n_q;
   assign ch4_aux_pin_a_o = aux_a_q;
   assign ch4_aux_pin_b_o = aux_b_q;

endmodule

// ==== design/pwm_timer_pkg.sv ====
package pwm_timer_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int NCH = 5;
   localparam int CW = 16;
   localparam int AW = 8;

   // ----------------------------------------------------------------
   // address map: addr[7:5] channel, addr[4:2] register in channel
   // ----------------------------------------------------------------
   localparam int CH_SEL_LSB = 5;
   localparam int REG_SEL_LSB = 2;
   localparam logic [2:0] REG_CTRL = 3'h0;
   localparam logic [2:0] REG_CNT = 3'h1;
   localparam logic [2:0] REG_GRA = 3'h2;
   localparam logic [2:0] REG_GRB = 3'h3;
   localparam logic [2:0] REG_STAT = 3'h4;
   localparam logic [7:0] ADDR_START = 8'hA0;
   localparam logic [7:0] ADDR_MODE = 8'hA4;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_CKS_LSB = 0;
   localparam int CTRL_CCLR_LSB = 2;
   localparam int CTRL_PWM_BIT = 4;
   localparam int CTRL_SYNC_BIT = 5;
   localparam int CTRL_W = 6;
   localparam int STAT_MFA_BIT = 0;
   localparam int STAT_MFB_BIT = 1;
   localparam int STAT_OVF_BIT = 2;
   localparam int STAT_W = 3;
   localparam int MODE_DIR_BIT = 2;

   // ----------------------------------------------------------------
   // reset values and codes
   // ----------------------------------------------------------------
   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
   localparam logic [CW-1:0] CNT_RST = 16'h0000;
   localparam logic [CW-1:0] CNT_MAX = 16'hFFFF;
   localparam logic [CW-1:0] GR_RST = 16'hFFFF;
   localparam logic [STAT_W-1:0] STAT_RST = 3'h0;
   localparam logic [NCH-1:0] STR_RST = 5'h00;
   localparam logic [2:0] PRESC_RST = 3'h0;
   localparam logic [1:0] CKS_DIV2 = 2'h1;
   localparam logic [1:0] CKS_DIV4 = 2'h2;
   localparam logic [1:0] CKS_DIV8 = 2'h3;
   localparam logic [2:0] PRESC_M1 = 3'h0;
   localparam logic [2:0] PRESC_M2 = 3'h1;
   localparam logic [2:0] PRESC_M4 = 3'h3;
   localparam logic [2:0] PRESC_M8 = 3'h7;
   localparam logic [1:0] MODE_CODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_CODE_RSYNC = 2'h1;
   localparam logic [1:0] MODE_CODE_COMPL = 2'h2;

   typedef enum logic [1:0] {MODE_NORMAL, MODE_RSYNC, MODE_COMPL} mode_t;
   typedef enum logic [1:0] {CLR_NONE, CLR_GRA, CLR_GRB, CLR_SYNC} clr_t;

endpackage

// ==== verification/pwm_timer_checker.sv ====
module pwm_timer_checker (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [pwm_timer_pkg::AW-1:0] addr_i,
   input wire logic [pwm_timer_pkg::CW-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [pwm_timer_pkg::CW-1:0] rdata_o,
   input wire logic [pwm_timer_pkg::NCH-1:0] chan_pin_a_o,
   input wire logic [pwm_timer_pkg::NCH-1:0] chan_pin_a_oe_n_o,
   input wire logic ch3_pin_b_o,
   input wire logic ch3_pin_b_oe_n_o,
   input wire logic ch4_pin_b_o,
   input wire logic ch4_pin_b_oe_n_o,
   input wire logic ch4_aux_pin_a_o,
   input wire logic ch4_aux_pin_b_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import pwm_timer_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // ----------------------------------------------------------------
   // mode shadow, rebuilt from bus writes since the mode is not a port
   // ----------------------------------------------------------------
   logic [1:0] mode_q;
   wire rsync = mode_q == MODE_CODE_RSYNC;
   always_ff @(posedge clk_i) begin
      if (!resetn_i) mode_q <= 2'h0;
      else if (wr_i && addr_i == ADDR_MODE) mode_q <= wdata_i[1:0];
   end
   AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
      else $error("read data not zero outside a read answer");
   AST_BAD_ADDR: assert property (rd_i && addr_i[1:0] != 2'h0 |=> rdata_o == 16'h0000)
      else $error("misaligned read returned data");
   AST_RESET_PINS: assert property ($past(!resetn_i) |-> chan_pin_a_oe_n_o == 5'h1F && ch3_pin_b_oe_n_o
      && ch4_pin_b_oe_n_o && chan_pin_a_o == 5'h00 && !ch4_aux_pin_a_o)
      else $error("pins not idle after reset");
   AST_OE_GROUP: assert property (!ch3_pin_b_oe_n_o |-> !ch4_pin_b_oe_n_o && chan_pin_a_oe_n_o[4:3] == 2'h0)
      else $error("pair pins not all driven together");
   AST_AUX_QUIET: assert property (ch3_pin_b_oe_n_o && $past(ch3_pin_b_oe_n_o, 2) |-> !ch4_aux_pin_a_o
      && !ch4_aux_pin_b_o)
      else $error("aux pins active outside combined modes");
   AST_PAIR1_APART: assert property (!ch3_pin_b_oe_n_o |-> !(chan_pin_a_o[3] && ch3_pin_b_o))
      else $error("pair one overlaps");
   AST_PAIR23_APART: assert property (!ch3_pin_b_oe_n_o |-> !(chan_pin_a_o[4] && ch4_aux_pin_a_o)
      && !(ch4_pin_b_o && ch4_aux_pin_b_o))
      else $error("pair two or three overlaps");
   AST_RSYNC_INV: assert property (rsync && $past(rsync, 3) |-> {ch3_pin_b_o, ch4_aux_pin_a_o, ch4_aux_pin_b_o}
      == ~{chan_pin_a_o[3], chan_pin_a_o[4], ch4_pin_b_o})
      else $error("reset-sync secondary not inverse of primary");
endmodule

// ==== verification/pwm_load_model.sv ====
module pwm_load_model (
   input wire logic clk_i,
   input wire logic clr_i,
   input wire logic en_i,
   input wire logic [8:0] pins_i,
   input wire logic [8:0] oe_n_i,
   output logic [15:0] hi_cnt_o [9]
);
   timeunit 1ns;
   timeprecision 1ps;
   // an undriven pin reads as low at the load, so a missing enable shows up as lost high time
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < 9; i++) begin
         if (clr_i) hi_cnt_o[i] <= 16'h0000;
         else if (en_i && pins_i[i] && !oe_n_i[i]) hi_cnt_o[i] <= hi_cnt_o[i] + 16'h0001;
      end
   end
endmodule

// ==== verification/tb_top.sv ====
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pwm_timer_pkg::*;
   logic clk_i, resetn_i, wr_i, rd_i, clr, en;
   logic [AW-1:0] addr_i;
   logic [CW-1:0] wdata_i, rdata_o, v, w;
   logic [NCH-1:0] chan_pin_a_o, chan_pin_a_oe_n_o;
   logic ch3_pin_b_o, ch3_pin_b_oe_n_o, ch4_pin_b_o, ch4_pin_b_oe_n_o, ch4_aux_pin_a_o, ch4_aux_pin_b_o;
   logic [15:0] hi [9];
   int err_count = 0;
   int checks_done = 0;
   int p;
   localparam logic [AW-1:0] ra[9] = '{8'h40, 8'h28, 8'h8C, 8'h10, ADDR_MODE, ADDR_START, 8'hC0, 8'h08, 8'h0A};
   localparam logic [CW-1:0] rv[9] = '{16'h0000, GR_RST, GR_RST, 16'h0000, 16'h0000, 16'h0000, 16'h0000, GR_RST,
      16'h0000};
   localparam clr_t tcl[5] = '{CLR_GRB, CLR_GRB, CLR_GRB, CLR_GRA, CLR_GRA};
   localparam int tga[5] = '{2, 8, 4, 5, 4};
   localparam int tgb[5] = '{5, 5, 4, 8, 4};
   localparam int thi[5] = '{3, 0, 0, 6, 5};
   localparam int pi[3] = '{3, 4, 7};
   localparam int si[3] = '{5, 6, 8};
   localparam int rr[3] = '{3, 5, 7};
   localparam int cr[3] = '{8, 10, 12};
   wire [8:0] pins = {ch4_aux_pin_b_o, ch4_pin_b_o, ch4_aux_pin_a_o, ch3_pin_b_o, chan_pin_a_o};
   wire [8:0] oe_n = {1'b0, ch4_pin_b_oe_n_o, 1'b0, ch3_pin_b_oe_n_o, chan_pin_a_oe_n_o};

   pwm_timer u_pwm_timer (.clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .chan_pin_a_o,
      .chan_pin_a_oe_n_o, .ch3_pin_b_o, .ch3_pin_b_oe_n_o, .ch4_pin_b_o, .ch4_pin_b_oe_n_o, .ch4_aux_pin_a_o,
      .ch4_aux_pin_b_o);
   pwm_load_model u_pwm_load_model (.clk_i(clk_i), .clr_i(clr), .en_i(en), .pins_i(pins), .oe_n_i(oe_n),
      .hi_cnt_o(hi));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // ----------------------------------------------------------------
   // bus and measurement tasks
   // ----------------------------------------------------------------
   task automatic wr(input logic [AW-1:0] a, input logic [CW-1:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [AW-1:0] a, output logic [CW-1:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      d = rdata_o;
   endtask
   task automatic chk(input logic [CW-1:0] got, input logic [CW-1:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [AW-1:0] a, input logic [CW-1:0] m, input logic [CW-1:0] e);
      logic [CW-1:0] d;
      rd(a, d);
      chk(d & m, e);
   endtask
   // window must be whole periods so the high count does not depend on phase
   task automatic meas(input int n);
      @(posedge clk_i);
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
      en <= 1'b1;
      repeat (n) @(posedge clk_i);
      en <= 1'b0;
      @(negedge clk_i);
   endtask
   task automatic pwm_run(input int ch, input clr_t c, input logic [CW-1:0] a, input logic [CW-1:0] b);
      logic [AW-1:0] base;
      base = AW'(ch * 32);
      wr(ADDR_START, 16'h0000);
      wr(base + 8'h04, 16'h0000);
      wr(base + 8'h08, a);
      wr(base + 8'h0C, b);
      wr(base, CW'((1 << CTRL_PWM_BIT) | (c << CTRL_CCLR_LSB)));
      wr(ADDR_START, CW'(1 << ch));
      repeat (20) @(posedge clk_i);
   endtask
   task automatic combo(input logic [1:0] m, input logic [CW-1:0] c3, input logic [CW-1:0] ctl3,
      input logic [CW-1:0] g3a, input logic [CW-1:0] r0, input logic [CW-1:0] r1, input logic [CW-1:0] r2);
      wr(ADDR_START, 16'h0000);
      wr(ADDR_MODE, 16'h0000);
      wr(ADDR_MODE, CW'(m));
      wr(8'h60, ctl3);
      wr(8'h80, 16'h0000);
      wr(8'h64, c3);
      wr(8'h84, 16'h0000);
      wr(8'h68, g3a);
      wr(8'h6C, r0);
      wr(8'h88, r1);
      wr(8'h8C, r2);
      wr(ADDR_START, 16'h0018);
      repeat (40) @(posedge clk_i);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge clk_i);
      err_count++;
      give_verdict();
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      resetn_i = 1'b0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 8'h00;
      wdata_i = 16'h0000;
      clr = 1'b0;
      en = 1'b0;
      repeat (3) @(posedge clk_i);
      resetn_i <= 1'b1;
      wr(8'hC0, 16'hFFFF);
      wr(8'h0A, 16'h1234);
      for (int i = 0; i < 9; i++) begin
         rc(ra[i], 16'hFFFF, rv[i]);
      end
      $display("register test done");
      for (int ch = 0; ch < NCH; ch++) begin
         for (int r = 0; r < 5; r++) begin
            p = (tcl[r] == CLR_GRA) ? tga[r] + 1 : tgb[r] + 1;
            pwm_run(ch, tcl[r], CW'(tga[r]), CW'(tgb[r]));
            meas(4 * p);
            chk(hi[ch], CW'(4 * thi[r]));
         end
      end
      $display("pwm test done");
      wr(ADDR_START, 16'h0000);
      wr(8'h00, 16'h0039);
      wr(8'h20, 16'h003D);
      wr(8'h08, 16'h0001);
      wr(8'h0C, 16'h0005);
      wr(8'h28, 16'h0002);
      wr(8'h2C, 16'h0004);
      wr(8'h04, 16'h0003);
      rc(8'h24, 16'hFFFF, 16'h0003);
      wr(8'h24, 16'h0000);
      wr(ADDR_START, 16'h0003);
      repeat (20) @(posedge clk_i);
      meas(48);
      chk(hi[0], 16'h0020);
      chk(hi[1], 16'h0010);
      $display("sync test done");
      combo(MODE_CODE_RSYNC, 16'h0000, 16'h0004, 16'h0009, 16'h0003, 16'h0005, 16'h0007);
      meas(40);
      for (int k = 0; k < 3; k++) begin
         chk(hi[pi[k]], CW'(4 * (rr[k] + 1)));
         chk(hi[si[k]], CW'(40 - 4 * (rr[k] + 1)));
      end
      rd(8'h84, v);
      rd(8'h84, w);
      chk(w - v, 16'h0002);
      chk(CW'(v > 16'h0007), 16'h0001);
      $display("reset-sync test done");
      wr(8'h70, 16'h0007);
      wr(8'h90, 16'h0007);
      combo(MODE_CODE_COMPL, 16'h0002, 16'h0000, 16'h0013, 16'h0008, 16'h000A, 16'h000C);
      meas(136);
      for (int k = 0; k < 3; k++) begin
         chk(hi[pi[k]], CW'(4 * (2 * cr[k] - 4)));
         chk(hi[si[k]], CW'(8 * (17 - cr[k])));
      end
      rc(8'h70, 16'h0005, 16'h0001);
      rc(8'h90, 16'h0004, 16'h0004);
      rc(ADDR_MODE, 16'h0003, 16'h0002);
      $display("complementary test done");
      give_verdict();
   end
endmodule

bind pwm_timer pwm_timer_checker u_pwm_timer_checker (.clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
   .rdata_o, .chan_pin_a_o, .chan_pin_a_oe_n_o, .ch3_pin_b_o, .ch3_pin_b_oe_n_o, .ch4_pin_b_o,
   .ch4_pin_b_oe_n_o, .ch4_aux_pin_a_o, .ch4_aux_pin_b_o);
